// >>> src/dual_adc_mode_sequencer.sv
// Mode, reset and calibration sequencer shared by the primary and auxiliary converters.
`timescale 1ns/1ps
// How it works
// R1: Mode 000 is power-down, the reset value.
// R2: Idle holds filter, modulator in reset; clocks run.
// R3: Single conversion updates results, then mode returns 000.
// R4: Continuous mode keeps updating results at rate.
// R5: Internal zero calibration selects internal input short.
// R6: Internal full calibration selects the chosen reference.
// R7: User applies zero-scale signal before system zero.
// R8: User applies full-scale signal before system full.
// R9: Any mode write resets both, except aux-only cases.
// R10: Primary control write while enabled resets both.
// R11: Auxiliary control write resets only the auxiliary.
// R12: Auxiliary restarts aligned to primary output timing.
// R13: Calibration write clears both ready flags immediately; an aux-only write clears only the auxiliary flag.
// R14: Calibration end writes coefficients, status, mode 000.
// R15: Auxiliary calibration on temperature sensor fails with error.
// R16: Calibrations run at maximum update rate setting.
// R17: Auxiliary range is fixed; primary range programmable.
// R18: Ready set at completion; results blocked until cleared.
// R19: Error on clamped result or failed calibration.
// R20: Enable bit selects shared mode, else power-down.
module dual_adc_mode_sequencer import adc_seq_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wr_data,
  input wire logic sfr_wr,
  output logic [7:0] sfr_rd_data,
  input wire logic prim_conv_done,
  input wire logic [23:0] prim_conv_data,
  input wire logic prim_clamped,
  input wire logic prim_cal_fail,
  input wire logic aux_conv_done,
  input wire logic [15:0] aux_conv_data,
  input wire logic aux_clamped,
  input wire logic aux_cal_fail,
  input wire logic no_ext_ref_pin,
  output logic prim_filter_rst,
  output logic aux_filter_rst,
  output logic prim_power_down,
  output logic aux_power_down,
  output logic mod_clk_en,
  output logic [1:0] prim_input_sel,
  output logic [1:0] aux_input_sel,
  output logic prim_ext_ref,
  output logic aux_ext_ref,
  output logic [1:0] prim_chan,
  output logic [1:0] aux_chan,
  output logic [2:0] prim_range,
  output logic prim_unipolar,
  output logic aux_unipolar,
  output logic [7:0] rate_eff,
  output logic prim_cal_wr,
  output logic aux_cal_wr,
  output logic [1:0] cal_kind
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] pcon;
    logic [7:0] acon;
    logic [7:0] rate;
    logic primary_done_flag;
    logic aux_done_flag;
    logic calst;
    logic primary_fault_flag;
    logic aux_fault_flag;
    logic pend0;
    logic pend1;
    logic aux_hold;
    seq_state_t seq;
    logic nx_meta;
    logic nx_sync;
    logic [7:0] rd_data;
    logic p_pd;
    logic a_pd;
    logic clk_en;
    logic [1:0] p_sel;
    logic [1:0] a_sel;
    logic [7:0] rate_eff;
    logic p_calwr;
    logic a_calwr;
    logic [1:0] cal_kind;
  } seq_reg_t;
  seq_reg_t st_reg;
  seq_reg_t st_next;

  logic mode_wr;
  logic pcon_wr;
  logic acon_wr;
  logic stat_wr;
  logic rate_wr;
  logic aux_only;
  logic p_rst_req;
  logic a_rst_req;
  logic p_hold;
  logic a_hold;
  logic p_ev;
  logic a_ev;
  logic p_load;
  logic a_load;
  logic [23:0] prim_result;
  logic [15:0] aux_result;
  op_mode_t cur_md;
  op_mode_t new_md;
  op_mode_t nx_md;

  assign cur_md = op_mode_t'(st_reg.mode[2:0]);
  assign new_md = op_mode_t'(sfr_wr_data[2:0]);
  assign mode_wr = sfr_wr && (sfr_addr == MODE_ADDR);
  assign pcon_wr = sfr_wr && (sfr_addr == PCON_ADDR);
  assign acon_wr = sfr_wr && (sfr_addr == ACON_ADDR);
  assign stat_wr = sfr_wr && (sfr_addr == STAT_ADDR);
  assign rate_wr = sfr_wr && (sfr_addr == RATE_ADDR);

  // Only raising the auxiliary enable, with the mode and primary enable kept, spares the primary.
  assign aux_only = mode_wr && (new_md == cur_md) && !st_reg.mode[MODE_EN1_BIT] && sfr_wr_data[MODE_EN1_BIT] &&
                    (sfr_wr_data[MODE_EN0_BIT] == st_reg.mode[MODE_EN0_BIT]);
  assign p_rst_req = (mode_wr && !aux_only) || (pcon_wr && st_reg.mode[MODE_EN0_BIT]); // see R9 see R10
  assign a_rst_req = p_rst_req || acon_wr || aux_only; // see R11

  // Completion events count only for an enabled converter in an active mode.
  assign p_ev = prim_conv_done && st_reg.mode[MODE_EN0_BIT] && (cur_md >= MD_SINGLE) && !prim_filter_rst;
  assign a_ev = aux_conv_done && st_reg.mode[MODE_EN1_BIT] && (cur_md >= MD_SINGLE) && !aux_filter_rst;
  assign p_load = p_ev && (st_reg.seq != SEQ_CALIB); // see R4
  assign a_load = a_ev && (st_reg.seq != SEQ_CALIB);

  always_comb begin
    st_next = st_reg;
    st_next.p_calwr = 1'b0;
    st_next.a_calwr = 1'b0;
    st_next.nx_meta = no_ext_ref_pin;
    st_next.nx_sync = st_reg.nx_meta;
    if (pcon_wr) begin
      st_next.pcon = sfr_wr_data & PCON_WMASK;
    end
    if (acon_wr) begin
      st_next.acon = sfr_wr_data & ACON_WMASK;
      st_next.aux_hold = st_reg.mode[MODE_EN0_BIT] && (cur_md >= MD_SINGLE) && !p_rst_req; // see R12
    end
    if (rate_wr) begin
      st_next.rate = sfr_wr_data;
    end
    if (stat_wr) begin
      st_next.primary_done_flag = st_reg.primary_done_flag && sfr_wr_data[STAT_PRIMARY_DONE_FLAG_BIT];
      st_next.aux_done_flag = st_reg.aux_done_flag && sfr_wr_data[STAT_AUX_DONE_FLAG_BIT];
    end
    if (mode_wr && aux_only) begin
      st_next.mode = sfr_wr_data & MODE_WMASK;
      st_next.pend1 = (new_md == MD_SINGLE) || (new_md >= MD_INT_ZERO);
      st_next.aux_done_flag = (new_md >= MD_SINGLE) ? 1'b0 : st_next.aux_done_flag;
      st_next.aux_fault_flag = 1'b0;
      st_next.aux_hold = st_reg.mode[MODE_EN0_BIT] && (cur_md >= MD_SINGLE); // see R12
    end else if (mode_wr) begin
      st_next.mode = sfr_wr_data & MODE_WMASK;
      st_next.primary_fault_flag = 1'b0; // see R19
      st_next.aux_fault_flag = 1'b0;
      st_next.calst = 1'b0;
      st_next.aux_hold = 1'b0;
      if (new_md >= MD_SINGLE) begin
        st_next.primary_done_flag = 1'b0; // see R13
        st_next.aux_done_flag = 1'b0;
      end
      st_next.pend0 = sfr_wr_data[MODE_EN0_BIT] && ((new_md == MD_SINGLE) || (new_md >= MD_INT_ZERO));
      st_next.pend1 = sfr_wr_data[MODE_EN1_BIT] && ((new_md == MD_SINGLE) || (new_md >= MD_INT_ZERO));
      case (new_md)
        MD_SINGLE: begin
          st_next.seq = SEQ_ONESHOT;
        end
        MD_CONTINUOUS: begin
          st_next.seq = SEQ_STREAM;
        end
        MD_INT_ZERO, MD_INT_FULL, MD_SYS_ZERO, MD_SYS_FULL: begin
          st_next.seq = SEQ_CALIB;
        end
        default: begin
          st_next.seq = SEQ_STOP;
        end
      endcase
    end
    // The auxiliary filter leaves reset on a primary output, so both run in step.
    if (prim_conv_done && st_reg.aux_hold && !acon_wr && !aux_only) begin
      st_next.aux_hold = 1'b0; // see R12
    end
    // Hardware events win over a clearing write arriving in the same cycle.
    if (p_ev) begin
      if (st_reg.seq == SEQ_CALIB) begin
        st_next.p_calwr = !prim_cal_fail && !st_reg.primary_done_flag; // see R14
        st_next.primary_fault_flag = st_next.primary_fault_flag || prim_cal_fail; // see R19
        st_next.calst = 1'b1;
      end else if (!st_reg.primary_done_flag) begin
        st_next.primary_fault_flag = st_next.primary_fault_flag || prim_clamped; // see R19
      end
      st_next.primary_done_flag = 1'b1; // see R18
      st_next.pend0 = mode_wr ? st_next.pend0 : 1'b0;
    end
    if (a_ev) begin
      if (st_reg.seq == SEQ_CALIB) begin
        // Temperature sensor input cannot be calibrated, so coefficients are kept.
        st_next.a_calwr = !aux_cal_fail && !st_reg.aux_done_flag &&
                          (st_reg.acon[CON_CH_HI:CON_CH_LO] != AUX_TEMP_SENSOR); // see R15
        st_next.aux_fault_flag = st_next.aux_fault_flag || aux_cal_fail ||
                       (st_reg.acon[CON_CH_HI:CON_CH_LO] == AUX_TEMP_SENSOR); // see R15
        st_next.calst = 1'b1;
      end else if (!st_reg.aux_done_flag) begin
        st_next.aux_fault_flag = st_next.aux_fault_flag || aux_clamped;
      end
      st_next.aux_done_flag = 1'b1;
      st_next.pend1 = mode_wr ? st_next.pend1 : 1'b0;
    end
    if (!mode_wr && ((st_reg.seq == SEQ_ONESHOT) || (st_reg.seq == SEQ_CALIB)) &&
        (st_reg.pend0 || st_reg.pend1) && !st_next.pend0 && !st_next.pend1) begin
      st_next.mode[2:0] = MD_POWERDOWN; // see R3 see R14
      st_next.seq = SEQ_STOP;
    end
    nx_md = op_mode_t'(st_next.mode[2:0]);
    st_next.p_pd = !st_next.mode[MODE_EN0_BIT] || (nx_md == MD_POWERDOWN); // see R1 see R20
    st_next.a_pd = !st_next.mode[MODE_EN1_BIT] || (nx_md == MD_POWERDOWN); // see R20
    st_next.clk_en = !(st_next.p_pd && st_next.a_pd); // see R2
    case (nx_md)
      MD_INT_ZERO: begin
        st_next.p_sel = SEL_SHORT; // see R5
        st_next.a_sel = SEL_SHORT;
      end
      MD_INT_FULL: begin
        st_next.p_sel = SEL_REF; // see R6
        st_next.a_sel = SEL_REF;
      end
      default: begin
        st_next.p_sel = SEL_PINS; // see R7 see R8
        st_next.a_sel = SEL_PINS;
      end
    endcase
    st_next.rate_eff = (nx_md >= MD_INT_ZERO) ? RATE_MAX : st_next.rate; // see R16
    st_next.cal_kind = st_next.mode[1:0];
    case (sfr_addr)
      MODE_ADDR: st_next.rd_data = st_reg.mode;
      PCON_ADDR: st_next.rd_data = st_reg.pcon;
      ACON_ADDR: st_next.rd_data = st_reg.acon;
      RATE_ADDR: st_next.rd_data = st_reg.rate;
      STAT_ADDR: begin
        st_next.rd_data = {st_reg.primary_done_flag, st_reg.aux_done_flag, st_reg.calst,
                           st_reg.nx_sync && !(st_reg.p_pd && st_reg.a_pd), st_reg.primary_fault_flag, st_reg.aux_fault_flag, 2'b00};
      end
      PRES_L_ADDR: st_next.rd_data = prim_result[7:0];
      PRES_M_ADDR: st_next.rd_data = prim_result[15:8];
      PRES_H_ADDR: st_next.rd_data = prim_result[23:16];
      ARES_L_ADDR: st_next.rd_data = aux_result[7:0];
      ARES_H_ADDR: st_next.rd_data = aux_result[15:8];
      default: st_next.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.mode <= MODE_RST;
      st_reg.pcon <= PCON_RST;
      st_reg.acon <= ACON_RST;
      st_reg.rate <= RATE_RST;
      st_reg.seq <= SEQ_STOP;
      st_reg.p_pd <= 1'b1;
      st_reg.a_pd <= 1'b1;
      st_reg.rate_eff <= RATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign p_hold = st_reg.p_pd || (cur_md == MD_IDLE); // see R2
  assign a_hold = st_reg.a_pd || (cur_md == MD_IDLE) || st_reg.aux_hold;

  filter_reset_gen prim_rst_gen (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .rst_req(p_rst_req),
    .rst_hold(p_hold),
    .filter_rst(prim_filter_rst)
  );

  filter_reset_gen aux_rst_gen (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .rst_req(a_rst_req),
    .rst_hold(a_hold),
    .filter_rst(aux_filter_rst)
  );

  result_capture #(.WIDTH(24)) prim_res (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(p_load),
    .ready(st_reg.primary_done_flag),
    .data_in(prim_conv_data),
    .data_out(prim_result)
  );

  result_capture #(.WIDTH(16)) aux_res (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(a_load),
    .ready(st_reg.aux_done_flag),
    .data_in(aux_conv_data),
    .data_out(aux_result)
  );

  assign sfr_rd_data = st_reg.rd_data;
  assign prim_power_down = st_reg.p_pd;
  assign aux_power_down = st_reg.a_pd;
  assign mod_clk_en = st_reg.clk_en;
  assign prim_input_sel = st_reg.p_sel;
  assign aux_input_sel = st_reg.a_sel;
  assign prim_ext_ref = st_reg.pcon[CON_XREF_BIT]; // see R6
  assign aux_ext_ref = st_reg.acon[CON_XREF_BIT];
  assign prim_chan = st_reg.pcon[CON_CH_HI:CON_CH_LO];
  assign aux_chan = st_reg.acon[CON_CH_HI:CON_CH_LO];
  assign prim_range = st_reg.pcon[CON_RANGE_HI:0]; // see R17
  assign prim_unipolar = st_reg.pcon[CON_UNI_BIT];
  assign aux_unipolar = st_reg.acon[CON_UNI_BIT];
  assign rate_eff = st_reg.rate_eff;
  assign prim_cal_wr = st_reg.p_calwr;
  assign aux_cal_wr = st_reg.a_calwr;
  assign cal_kind = st_reg.cal_kind;

  a_idle_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R2
    (cur_md == MD_IDLE) && st_reg.mode[MODE_EN0_BIT] |-> prim_filter_rst && mod_clk_en)
    else $error("Idle mode did not hold the primary filter with clocks running");
  a_single_return: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R3
    (st_reg.seq == SEQ_ONESHOT) && st_reg.pend0 && !st_reg.pend1 && p_ev && !mode_wr
    |=> (cur_md == MD_POWERDOWN) && st_reg.primary_done_flag)
    else $error("Single conversion did not return to power-down");
  a_zero_short: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R5
    (cur_md == MD_INT_ZERO) |-> (prim_input_sel == SEL_SHORT) && (aux_input_sel == SEL_SHORT))
    else $error("Zero-scale calibration without internal short");
  a_mode_write_reset: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R9
    mode_wr && !aux_only |=> prim_filter_rst && aux_filter_rst [*2])
    else $error("Mode write did not reset both converters");
  a_pcon_reset: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R10
    pcon_wr && st_reg.mode[MODE_EN0_BIT] |=> prim_filter_rst && aux_filter_rst)
    else $error("Primary control write did not reset both converters");
  a_acon_aux_only: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R11
    acon_wr && !mode_wr && !pcon_wr && !prim_filter_rst && !p_hold |=> aux_filter_rst && !prim_filter_rst)
    else $error("Auxiliary control write disturbed the primary converter");
  a_cal_clears_ready: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R13
    mode_wr && !aux_only && (new_md >= MD_INT_ZERO) && !p_ev && !a_ev |=> !st_reg.primary_done_flag && !st_reg.aux_done_flag)
    else $error("Calibration write did not clear the ready flags");
  a_temp_cal_fails: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R15
    a_ev && (st_reg.seq == SEQ_CALIB) && (st_reg.acon[CON_CH_HI:CON_CH_LO] == AUX_TEMP_SENSOR)
    |=> !aux_cal_wr && st_reg.aux_fault_flag && st_reg.aux_done_flag)
    else $error("Temperature sensor calibration wrote coefficients");
  a_cal_max_rate: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R16
    (cur_md >= MD_INT_ZERO) |-> (rate_eff == RATE_MAX))
    else $error("Calibration not run at maximum update rate");
  a_ready_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R18
    st_reg.primary_done_flag && prim_conv_done |=> $stable(prim_result))
    else $error("Primary result overwritten while ready was set");
  a_disabled_pd: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R20
    !st_reg.mode[MODE_EN0_BIT] |-> prim_power_down ##1 (prim_filter_rst || st_reg.mode[MODE_EN0_BIT]))
    else $error("Disabled primary converter not powered down");
endmodule

// >>> src/adc_seq_pkg.sv
// Constants, register map and types shared by the converter mode sequencer.
package adc_seq_pkg;
  localparam logic [7:0] MODE_ADDR = 8'hD1;
  localparam logic [7:0] PCON_ADDR = 8'hD2;
  localparam logic [7:0] ACON_ADDR = 8'hD3;
  localparam logic [7:0] RATE_ADDR = 8'hD4;
  localparam logic [7:0] STAT_ADDR = 8'hD8;
  localparam logic [7:0] PRES_L_ADDR = 8'hD9;
  localparam logic [7:0] PRES_M_ADDR = 8'hDA;
  localparam logic [7:0] PRES_H_ADDR = 8'hDB;
  localparam logic [7:0] ARES_L_ADDR = 8'hDC;
  localparam logic [7:0] ARES_H_ADDR = 8'hDD;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PCON_RST = 8'h07;
  localparam logic [7:0] ACON_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h45;
  localparam logic [7:0] RATE_MAX = 8'hFF;
  localparam logic [7:0] MODE_WMASK = 8'h37;
  localparam logic [7:0] PCON_WMASK = 8'h7F;
  localparam logic [7:0] ACON_WMASK = 8'h78;
  localparam int MODE_EN0_BIT = 5;
  localparam int MODE_EN1_BIT = 4;
  localparam int CON_XREF_BIT = 6;
  localparam int CON_CH_HI = 5;
  localparam int CON_CH_LO = 4;
  localparam int CON_UNI_BIT = 3;
  localparam int CON_RANGE_HI = 2;
  localparam int STAT_PRIMARY_DONE_FLAG_BIT = 7;
  localparam int STAT_AUX_DONE_FLAG_BIT = 6;
  localparam logic [1:0] AUX_TEMP_SENSOR = 2'h2;
  localparam logic [1:0] SEL_PINS = 2'h0;
  localparam logic [1:0] SEL_SHORT = 2'h1;
  localparam logic [1:0] SEL_REF = 2'h2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_RST_NS = 200;
  localparam logic [3:0] FILTER_RST_CYCLES = 4'((FILTER_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    MD_POWERDOWN = 3'h0, MD_IDLE = 3'h1, MD_SINGLE = 3'h2, MD_CONTINUOUS = 3'h3,
    MD_INT_ZERO = 3'h4, MD_INT_FULL = 3'h5, MD_SYS_ZERO = 3'h6, MD_SYS_FULL = 3'h7
  } op_mode_t;
  typedef enum logic [3:0] {
    SEQ_STOP = 4'h1, SEQ_ONESHOT = 4'h2, SEQ_STREAM = 4'h4, SEQ_CALIB = 4'h8
  } seq_state_t;
endpackage

// >>> src/filter_reset_gen.sv
// Holds one converter's filter and modulator in reset for a request or a level.
`timescale 1ns/1ps
module filter_reset_gen import adc_seq_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic rst_req,
  input wire logic rst_hold,
  output logic filter_rst
);
  typedef struct packed {
    logic [3:0] cnt;
    logic rst;
  } rg_state_t;
  rg_state_t st_reg;
  rg_state_t st_next;

  // A request restarts the count, so back-to-back writes stretch the reset.
  always_comb begin
    st_next = st_reg;
    if (rst_req) begin
      st_next.cnt = FILTER_RST_CYCLES;
    end else if (st_reg.cnt != 4'h0) begin
      st_next.cnt = st_reg.cnt - 4'h1;
    end
    st_next.rst = rst_req || rst_hold || (st_next.cnt != 4'h0);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{cnt: 4'h0, rst: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign filter_rst = st_reg.rst;
endmodule

// >>> src/result_capture.sv
// Result holding register that refuses new data while its ready flag is set.
`timescale 1ns/1ps
module result_capture import adc_seq_pkg::*; #(
  parameter int WIDTH = 24
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic ready,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  typedef struct packed {
    logic [WIDTH-1:0] data;
  } rc_state_t;
  rc_state_t st_reg;
  rc_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (load && !ready) begin // see R18
      st_next.data = data_in;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.data;
endmodule

// >>> verif/dual_adc_mode_sequencer_tb.sv
// Self-checking testbench for the converter mode sequencer.
`timescale 1ns/1ps
module dual_adc_mode_sequencer_tb import adc_seq_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wr_data = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_rd_data;
  logic prim_conv_done = 1'b0;
  logic [23:0] prim_conv_data = 24'h000000;
  logic prim_clamped = 1'b0;
  logic prim_cal_fail = 1'b0;
  logic aux_conv_done = 1'b0;
  logic [15:0] aux_conv_data = 16'h0000;
  logic aux_clamped = 1'b0;
  logic aux_cal_fail = 1'b0;
  logic no_ext_ref_pin = 1'b0;
  logic prim_filter_rst, aux_filter_rst, prim_power_down, aux_power_down, mod_clk_en;
  logic [1:0] prim_input_sel, aux_input_sel, prim_chan, aux_chan, cal_kind;
  logic prim_ext_ref, aux_ext_ref, prim_unipolar, aux_unipolar, prim_cal_wr, aux_cal_wr;
  logic [2:0] prim_range;
  logic [7:0] rate_eff;
  int fails = 0;
  int check_count = 0;
  int seed = 32'h877C;

  dual_adc_mode_sequencer DUT (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wr_data(sfr_wr_data), .sfr_wr(sfr_wr), .sfr_rd_data(sfr_rd_data), .prim_conv_done(prim_conv_done),
    .prim_conv_data(prim_conv_data), .prim_clamped(prim_clamped), .prim_cal_fail(prim_cal_fail),
    .aux_conv_done(aux_conv_done), .aux_conv_data(aux_conv_data), .aux_clamped(aux_clamped),
    .aux_cal_fail(aux_cal_fail), .no_ext_ref_pin(no_ext_ref_pin), .prim_filter_rst(prim_filter_rst),
    .aux_filter_rst(aux_filter_rst), .prim_power_down(prim_power_down), .aux_power_down(aux_power_down),
    .mod_clk_en(mod_clk_en), .prim_input_sel(prim_input_sel), .aux_input_sel(aux_input_sel),
    .prim_ext_ref(prim_ext_ref), .aux_ext_ref(aux_ext_ref), .prim_chan(prim_chan), .aux_chan(aux_chan),
    .prim_range(prim_range), .prim_unipolar(prim_unipolar), .aux_unipolar(aux_unipolar),
    .rate_eff(rate_eff), .prim_cal_wr(prim_cal_wr), .aux_cal_wr(aux_cal_wr), .cal_kind(cal_kind));

  always #10 ref_clk = ~ref_clk;

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Input selection that a calibration of the given kind should route to the converter.
  function automatic logic [1:0] sel_for(input logic [2:0] k);
    return (k == MD_INT_ZERO) ? SEL_SHORT : (k == MD_INT_FULL) ? SEL_REF : SEL_PINS;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wr_data = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    @(negedge ref_clk);
    d = sfr_rd_data;
  endtask

  task automatic res(input int sel, output logic [23:0] r);
    logic [7:0] b0, b1, b2;
    rd(sel == 0 ? PRES_L_ADDR : ARES_L_ADDR, b0);
    rd(sel == 0 ? PRES_M_ADDR : ARES_H_ADDR, b1);
    rd(PRES_H_ADDR, b2);
    r = (sel == 0) ? {b2, b1, b0} : {8'h00, b1, b0};
  endtask

  task automatic wait_low(input int sel, input int bound);
    int n;
    n = 0;
    while (((sel == 0) ? prim_filter_rst : aux_filter_rst) !== 1'b0) begin
      @(negedge ref_clk);
      n++;
      if (n > bound) begin
        fails++;
        $display("[FAIL] filter reset release expected 0 seen 1");
        give_verdict();
      end
    end
  endtask

  task automatic pulse(input int sel, input logic [23:0] d, input logic clamp, input logic fail);
    @(negedge ref_clk);
    if (sel == 0) begin
      {prim_conv_done, prim_conv_data, prim_clamped, prim_cal_fail} = {1'b1, d, clamp, fail};
    end else begin
      {aux_conv_done, aux_conv_data} = {1'b1, d[15:0]};
    end
    @(negedge ref_clk);
    prim_conv_done = 1'b0;
    aux_conv_done = 1'b0;
    prim_cal_fail = 1'b0;
    prim_clamped = 1'b0;
  endtask

  task automatic count_wr(input int sel, output int cnt);
    cnt = 0;
    for (int i = 0; i < 4; i++) begin
      if (((sel == 0) ? prim_cal_wr : aux_cal_wr) === 1'b1) cnt++;
      @(negedge ref_clk);
    end
  endtask

  initial begin
    logic [7:0] v;
    logic [23:0] d, d1, r;
    int cnt;
    logic [2:0] k;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    chk("prim_power_down", prim_power_down, 1);
    chk("aux_power_down", aux_power_down, 1);
    chk("mod_clk_en", mod_clk_en, 0);
    chk("prim_range", prim_range, 7);
    rd(MODE_ADDR, v); chk("mode reset", v, MODE_RST);
    rd(PCON_ADDR, v); chk("pcon reset", v, PCON_RST);
    rd(ACON_ADDR, v); chk("acon reset", v, ACON_RST);
    wr(8'hD0, 8'hA5); rd(8'hD0, v); chk("unmapped", v, 0);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(PCON_ADDR, v); wr(ACON_ADDR, v);
      chk("prim_range", prim_range, v[2:0]);
      chk("prim_chan", prim_chan, v[CON_CH_HI:CON_CH_LO]);
      chk("aux_chan", aux_chan, v[CON_CH_HI:CON_CH_LO]);
      chk("prim_ext_ref", prim_ext_ref, v[CON_XREF_BIT]);
      chk("aux_ext_ref", aux_ext_ref, v[CON_XREF_BIT]);
      chk("prim_unipolar", prim_unipolar, v[CON_UNI_BIT]);
      chk("aux_unipolar", aux_unipolar, v[CON_UNI_BIT]);
      rd(PCON_ADDR, d[7:0]); chk("pcon", d[7:0], v & PCON_WMASK);
      rd(ACON_ADDR, d[7:0]); chk("acon no range", d[7:0], v & ACON_WMASK);
    end
    wr(PCON_ADDR, 8'h47); wr(ACON_ADDR, 8'h00); wr(RATE_ADDR, RATE_RST);
    wr(MODE_ADDR, 8'h31);
    repeat (15) @(negedge ref_clk);
    chk("idle prim rst", prim_filter_rst, 1);
    chk("idle aux rst", aux_filter_rst, 1);
    chk("idle clocks", mod_clk_en, 1);
    chk("idle powered", prim_power_down, 0);
    chk("idle aux powered", aux_power_down, 0);
    // The missing-reference pin passes two synchroniser stages before the status bit shows it.
    no_ext_ref_pin = 1'b1;
    repeat (2) @(negedge ref_clk);
    rd(STAT_ADDR, v); chk("no ref flag", v & 8'h10, 8'h10);
    no_ext_ref_pin = 1'b0;
    repeat (2) @(negedge ref_clk);
    rd(STAT_ADDR, v); chk("no ref cleared", v & 8'h10, 0);
    wr(MODE_ADDR, 8'h22);
    chk("single start rst", prim_filter_rst, 1);
    wait_low(0, 30);
    d = 24'($random(seed));
    pulse(0, d, 0, 0);
    repeat (2) @(negedge ref_clk);
    chk("single power down", prim_power_down, 1);
    rd(MODE_ADDR, v); chk("single mode back", v, 8'h20);
    rd(STAT_ADDR, v); chk("single status", v & 8'hC8, 8'h80);
    res(0, r); chk("single result", r, d);
    wr(MODE_ADDR, 8'h23);
    wait_low(0, 30);
    d1 = 24'($random(seed));
    pulse(0, d1, 0, 0);
    res(0, r); chk("cont result", r, d1);
    pulse(0, ~d1, 0, 0);
    res(0, r); chk("blocked result", r, d1);
    wr(STAT_ADDR, 8'h00);
    rd(STAT_ADDR, v); chk("ready cleared", v & 8'h80, 0);
    d = 24'hFFFFFF;
    pulse(0, d, 1, 0);
    res(0, r); chk("cont result 2", r, d);
    rd(STAT_ADDR, v); chk("clamp error", v & 8'h88, 8'h88);
    wr(MODE_ADDR, 8'h23);
    chk("same mode rst", prim_filter_rst, 1);
    rd(STAT_ADDR, v); chk("error cleared", v & 8'h08, 0);
    wait_low(0, 30);
    wr(PCON_ADDR, 8'h47);
    chk("pcon write rst", prim_filter_rst, 1);
    wr(MODE_ADDR, 8'h33);
    wait_low(0, 30);
    pulse(0, 24'h123456, 0, 0);
    wait_low(1, 30);
    wr(ACON_ADDR, 8'h08);
    chk("acon aux rst", aux_filter_rst, 1);
    chk("acon prim runs", prim_filter_rst, 0);
    repeat (14) @(negedge ref_clk);
    chk("aux aligned hold", aux_filter_rst, 1);
    pulse(0, 24'h654321, 0, 0);
    wait_low(1, 14);
    chk("aux unipolar", aux_unipolar, 1);
    for (int i = 4; i < 8; i++) begin
      k = 3'(i);
      // System calibrations assume the bench has applied the zero or full-scale input
      wr(MODE_ADDR, {5'b00100, k});
      rd(STAT_ADDR, v); chk("cal ready clear", v & 8'hC0, 0);
      chk("cal rate", rate_eff, RATE_MAX);
      chk("cal kind", cal_kind, k[1:0]);
      chk("cal input sel", prim_input_sel, sel_for(k));
      chk("cal ref", prim_ext_ref, 1);
      wait_low(0, 30);
      pulse(0, 24'($random(seed)), 0, k == 3'h7);
      count_wr(0, cnt); chk("cal write pulses", cnt, (k == 3'h7) ? 0 : 1);
      rd(MODE_ADDR, v); chk("cal mode back", v, 8'h20);
      rd(STAT_ADDR, v); chk("cal status", v & 8'hA8, (k == 3'h7) ? 8'hA8 : 8'hA0);
    end
    wr(MODE_ADDR, 8'h00);
    wr(ACON_ADDR, 8'h20);
    wr(MODE_ADDR, 8'h14);
    wait_low(1, 30);
    chk("aux short", aux_input_sel, SEL_SHORT);
    pulse(1, 24'($random(seed)), 0, 0);
    count_wr(1, cnt); chk("temp cal write", cnt, 0);
    rd(STAT_ADDR, v); chk("temp cal status", v & 8'h64, 8'h64);
    rd(MODE_ADDR, v); chk("temp cal mode", v, 8'h10);
    give_verdict();
  end
endmodule
